// ==== hdl/aie_pkg.sv ====
// Purpose: Shared constants and carriers for the add/and execute block
// Assumes: 16-bit instruction words, 8-bit data path
// Notes:   Status flags travel as one packed struct
package aie_pkg;
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 12;
   localparam int          BANK_W        = 4;
   localparam logic [7:0]  OPC_ADD_LIT   = 8'h0f;
   localparam logic [7:0]  OPC_AND_LIT   = 8'h0b;
   localparam logic [5:0]  OPC_ADD_FILE  = 6'h09;
   localparam logic [5:0]  OPC_ADDC_FILE = 6'h08;
   localparam int          OPC8_HI       = 15;
   localparam int          OPC8_LO       = 8;
   localparam int          OPC6_LO       = 10;
   localparam int          DEST_BIT      = 9;
   localparam int          BANK_BIT      = 8;
   localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
   localparam logic [7:0]  ACC_HI_SPLIT  = 8'h60;
   localparam logic [3:0]  ACC_HI_BANK   = 4'hf;
   localparam logic [3:0]  ACC_LO_BANK   = 4'h0;
   localparam logic [7:0]  ZERO8         = 8'h00;
   localparam int          HALF_W        = 4;

   typedef struct packed {
      logic neg;
      logic signed_excess_flag;
      logic zero;
      logic half_carry_flag;
      logic carry;
   } aie_flags_t;

   typedef enum logic [1:0] {
      PH_DECODE  = 2'b00,
      PH_READ    = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE   = 2'b11
   } aie_phase_t;

   typedef enum logic [2:0] {
      OP_NONE          = 3'b000,
      OP_ADD_LITERAL   = 3'b001,
      OP_ADD_ACC_FILE  = 3'b010,
      OP_ADD_ACC_FILEC = 3'b011,
      OP_AND_LITERAL   = 3'b100
   } aie_op_t;
endpackage

// ==== hdl/aie_execute.sv ====
// Purpose: Executes add literal, add acc to file, add with carry and AND literal
// Assumes: One instruction word presented per four-phase instruction cycle
// Notes:   Data memory read returns combinationally in the read phase
//
// How it works
// - Opcode 0000_1111 adds the literal to the accumulator and stores it there.
// - Opcode 0010_01da adds the accumulator to the file byte and sends the sum to the destination.
// - Opcode 0010_00da adds accumulator, file byte and carry and sends it to the destination.
// - All three adds update negative, overflow, carry, half carry and zero flags.
// - Destination bit 0 writes the accumulator, 1 writes the file register back.
// - Bank bit 0 uses the access bank, 1 uses the bank select register for the bank.
// - Bank bit 0 with extended set on and address up to 95 uses indexed literal offset.
// - Opcode 0000_1011 ANDs the literal into the accumulator, touching only negative and zero.
// - Each instruction is one word and finishes within one instruction cycle.
`timescale 1ns/1ps
module aie_execute (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       instr_valid_in,
   input  wire logic [15:0]                instr_in,
   input  wire logic [aie_pkg::BANK_W-1:0] bank_select_reg_in,
   input  wire logic                       ext_set_en_in,
   input  wire logic [aie_pkg::ADDR_W-1:0] index_base_in,
   input  wire logic [aie_pkg::DATA_W-1:0] mem_rdata_in,
   output logic      [aie_pkg::ADDR_W-1:0] mem_addr_out,
   output logic                            mem_rd_out,
   output logic                            mem_wr_out,
   output logic      [aie_pkg::DATA_W-1:0] mem_wdata_out,
   output logic      [aie_pkg::DATA_W-1:0] acc_out,
   output aie_pkg::aie_flags_t             flags_out,
   output logic      [1:0]                 phase_out,
   output logic                            done_out
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   aie_pkg::aie_phase_t           ph_q, ph_d;
   aie_pkg::aie_op_t              op_q, op_d;
   logic [7:0]                    lit_q, lit_d;
   logic                          dest_q, dest_d;
   logic [aie_pkg::ADDR_W-1:0]    addr_q, addr_d;
   logic [aie_pkg::DATA_W-1:0]    opnd_q, opnd_d;
   logic [aie_pkg::DATA_W-1:0]    res_q, res_d;
   logic [aie_pkg::DATA_W-1:0]    acc_q, acc_d;
   aie_pkg::aie_flags_t           fl_q, fl_d, fl_new;
   logic                          rd_q, rd_d, wr_q, wr_d, done_q, done_d;
   logic [aie_pkg::DATA_W-1:0]    wdata_q, wdata_d;
   logic [aie_pkg::HALF_W:0]      lo_sum;
   logic [aie_pkg::DATA_W:0]      sum;
   logic                          cin;
   logic [7:0]                    fa;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      ph_d    = ph_q;
      op_d    = op_q;
      lit_d   = lit_q;
      dest_d  = dest_q;
      addr_d  = addr_q;
      opnd_d  = opnd_q;
      res_d   = res_q;
      acc_d   = acc_q;
      fl_d    = fl_q;
      fl_new  = fl_q;
      rd_d    = 1'b0;
      wr_d    = 1'b0;
      done_d  = 1'b0;
      wdata_d = wdata_q;
      fa      = instr_in[7:0];
      cin     = (op_q == aie_pkg::OP_ADD_ACC_FILEC) ? fl_q.carry : 1'b0;
      lo_sum  = {1'b0, acc_q[aie_pkg::HALF_W-1:0]} + {1'b0, opnd_q[aie_pkg::HALF_W-1:0]}
                + {{aie_pkg::HALF_W{1'b0}}, cin};
      sum     = {1'b0, acc_q} + {1'b0, opnd_q} + {{aie_pkg::DATA_W{1'b0}}, cin};
      unique case (ph_q)
         aie_pkg::PH_DECODE: begin
            op_d = aie_pkg::OP_NONE;
            if (instr_valid_in) begin
               ph_d   = aie_pkg::PH_READ;
               lit_d  = instr_in[7:0];
               dest_d = instr_in[aie_pkg::DEST_BIT];
               if (instr_in[aie_pkg::OPC8_HI:aie_pkg::OPC8_LO] == aie_pkg::OPC_ADD_LIT)
                  op_d = aie_pkg::OP_ADD_LITERAL;
               else if (instr_in[aie_pkg::OPC8_HI:aie_pkg::OPC8_LO] == aie_pkg::OPC_AND_LIT)
                  op_d = aie_pkg::OP_AND_LITERAL;
               else if (instr_in[aie_pkg::OPC8_HI:aie_pkg::OPC6_LO] == aie_pkg::OPC_ADD_FILE)
                  op_d = aie_pkg::OP_ADD_ACC_FILE;
               else if (instr_in[aie_pkg::OPC8_HI:aie_pkg::OPC6_LO] == aie_pkg::OPC_ADDC_FILE)
                  op_d = aie_pkg::OP_ADD_ACC_FILEC;
               if (instr_in[aie_pkg::BANK_BIT])
                  addr_d = {bank_select_reg_in, fa};
               else if (ext_set_en_in && fa <= aie_pkg::IDX_LIMIT)
                  addr_d = index_base_in + {4'h0, fa};
               else if (fa < aie_pkg::ACC_HI_SPLIT)
                  addr_d = {aie_pkg::ACC_LO_BANK, fa};
               else
                  addr_d = {aie_pkg::ACC_HI_BANK, fa};
               rd_d = (instr_in[aie_pkg::OPC8_HI:aie_pkg::OPC6_LO] == aie_pkg::OPC_ADD_FILE)
                    | (instr_in[aie_pkg::OPC8_HI:aie_pkg::OPC6_LO] == aie_pkg::OPC_ADDC_FILE);
            end
         end
         aie_pkg::PH_READ: begin
            ph_d   = aie_pkg::PH_PROCESS;
            opnd_d = (op_q == aie_pkg::OP_ADD_ACC_FILE || op_q == aie_pkg::OP_ADD_ACC_FILEC)
                   ? mem_rdata_in : lit_q;
         end
         aie_pkg::PH_PROCESS: begin
            ph_d = aie_pkg::PH_WRITE;
            if (op_q == aie_pkg::OP_AND_LITERAL) begin
               res_d       = acc_q & opnd_q;
               fl_new.neg  = res_d[aie_pkg::DATA_W-1];
               fl_new.zero = (res_d == aie_pkg::ZERO8);
            end else if (op_q != aie_pkg::OP_NONE) begin
               res_d                     = sum[aie_pkg::DATA_W-1:0];
               fl_new.neg                = res_d[aie_pkg::DATA_W-1];
               fl_new.zero               = (res_d == aie_pkg::ZERO8);
               fl_new.carry              = sum[aie_pkg::DATA_W];
               fl_new.half_carry_flag    = lo_sum[aie_pkg::HALF_W];
               fl_new.signed_excess_flag = (acc_q[7] == opnd_q[7]) && (res_d[7] != acc_q[7]);
            end
            fl_d = fl_new;
         end
         aie_pkg::PH_WRITE: begin
            ph_d   = aie_pkg::PH_DECODE;
            done_d = (op_q != aie_pkg::OP_NONE);
            if (op_q == aie_pkg::OP_ADD_LITERAL || op_q == aie_pkg::OP_AND_LITERAL
                || (op_q != aie_pkg::OP_NONE && !dest_q)) begin
               acc_d = res_q;
            end else if (op_q != aie_pkg::OP_NONE) begin
               wr_d    = 1'b1;
               wdata_d = res_q;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ph_q    <= aie_pkg::PH_DECODE;
         op_q    <= aie_pkg::OP_NONE;
         lit_q   <= '0;
         dest_q  <= 1'b0;
         addr_q  <= '0;
         opnd_q  <= '0;
         res_q   <= '0;
         acc_q   <= '0;
         fl_q    <= '0;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         done_q  <= 1'b0;
         wdata_q <= '0;
      end else begin
         ph_q    <= ph_d;
         op_q    <= op_d;
         lit_q   <= lit_d;
         dest_q  <= dest_d;
         addr_q  <= addr_d;
         opnd_q  <= opnd_d;
         res_q   <= res_d;
         acc_q   <= acc_d;
         fl_q    <= fl_d;
         rd_q    <= rd_d;
         wr_q    <= wr_d;
         done_q  <= done_d;
         wdata_q <= wdata_d;
      end
   end

   assign mem_addr_out  = addr_q;
   assign mem_rd_out    = rd_q;
   assign mem_wr_out    = wr_q;
   assign mem_wdata_out = wdata_q;
   assign acc_out       = acc_q;
   assign flags_out     = fl_q;
   assign phase_out     = ph_q;
   assign done_out      = done_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_and_keeps_flags: assert property (@(posedge clk_in) disable iff (rst_in)
      ph_q == aie_pkg::PH_PROCESS && op_q == aie_pkg::OP_AND_LITERAL
      |=> fl_q.carry == $past(fl_q.carry) && fl_q.signed_excess_flag == $past(fl_q.signed_excess_flag))
      else $error("AND changed carry or overflow");
   a_cycle_four_phases: assert property (@(posedge clk_in) disable iff (rst_in)
      ph_q == aie_pkg::PH_READ |=> ph_q == aie_pkg::PH_PROCESS ##1 ph_q == aie_pkg::PH_WRITE
      ##1 ph_q == aie_pkg::PH_DECODE)
      else $error("Phase sequence broken");
   a_read_strobe_phase: assert property (@(posedge clk_in) disable iff (rst_in)
      mem_rd_out |-> ph_q == aie_pkg::PH_READ)
      else $error("Read outside read phase");
   a_write_strobe_phase: assert property (@(posedge clk_in) disable iff (rst_in)
      mem_wr_out |-> $past(ph_q) == aie_pkg::PH_WRITE && dest_q && $past(op_q) inside
      {aie_pkg::OP_ADD_ACC_FILE, aie_pkg::OP_ADD_ACC_FILEC})
      else $error("File write without file destination");
   a_acc_dest_write: assert property (@(posedge clk_in) disable iff (rst_in)
      ph_q == aie_pkg::PH_WRITE && op_q == aie_pkg::OP_ADD_ACC_FILE && !dest_q
      |=> acc_q == $past(res_q) && !mem_wr_out)
      else $error("Accumulator destination not written");
   a_zero_flag_match: assert property (@(posedge clk_in) disable iff (rst_in)
      ph_q == aie_pkg::PH_PROCESS && op_q != aie_pkg::OP_NONE |=> fl_q.zero == (res_q == aie_pkg::ZERO8))
      else $error("Zero flag wrong");
   a_add_literal_sum: assert property (@(posedge clk_in) disable iff (rst_in)
      ph_q == aie_pkg::PH_PROCESS && op_q == aie_pkg::OP_ADD_LITERAL
      |=> res_q == ($past(acc_q) + $past(opnd_q)) ##1 acc_q == $past(res_q))
      else $error("Literal add wrong");
   a_carry_in_used: assert property (@(posedge clk_in) disable iff (rst_in)
      ph_q == aie_pkg::PH_PROCESS && op_q == aie_pkg::OP_ADD_ACC_FILEC
      |=> res_q == 8'($past(acc_q) + $past(opnd_q) + {7'h00, $past(fl_q.carry)}))
      else $error("Carry add wrong");
   a_bank_address: assert property (@(posedge clk_in) disable iff (rst_in)
      ph_q == aie_pkg::PH_DECODE && instr_valid_in && instr_in[aie_pkg::BANK_BIT]
      |=> mem_addr_out == {$past(bank_select_reg_in), $past(instr_in[7:0])})
      else $error("Banked address wrong");
   c_add_file: cover property (@(posedge clk_in) done_out && mem_wr_out);
   c_add_carry: cover property (@(posedge clk_in) op_q == aie_pkg::OP_ADD_ACC_FILEC && fl_q.carry);
   c_and_lit: cover property (@(posedge clk_in) op_q == aie_pkg::OP_AND_LITERAL && done_out);
   c_indexed: cover property (@(posedge clk_in) instr_valid_in && ext_set_en_in && !instr_in[aie_pkg::BANK_BIT]);
endmodule // aie_execute

// ==== tb/aie_data_mem.sv ====
// Purpose: Data memory model on the far side of the execute block
// Assumes: Read data returned combinationally while the read strobe is high
// Notes:   Outside a read the data lines show the inverse of the last read
`timescale 1ns/1ps
module aie_data_mem (
   input  wire logic                       clk_in,
   input  wire logic [aie_pkg::ADDR_W-1:0] addr_in,
   input  wire logic                       rd_in,
   input  wire logic                       wr_in,
   input  wire logic [aie_pkg::DATA_W-1:0] wdata_in,
   output logic      [aie_pkg::DATA_W-1:0] rdata_out
);
   logic [7:0] mem [4096];
   logic [7:0] last_q = 8'h00;
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37 + 11);
   end
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      if (wr_in) mem[addr_in] <= wdata_in;
      if (rd_in) last_q <= mem[addr_in];
   end
   assign rdata_out = rd_in ? mem[addr_in] : ~last_q;
endmodule // aie_data_mem

// ==== tb/add_and_instruction_execute_bench.sv ====
// Purpose: Self-checking bench for the add/and execute block
// Assumes: Inputs driven at the falling edge, one instruction per cycle group
// Notes:   Operand fields are scrambled while an instruction is in flight
`timescale 1ns/1ps
module add_and_instruction_execute_bench;
   logic                clk_in = 0, rst_in = 1, instr_valid_in = 0, ext_set_en_in = 0;
   logic [15:0]         instr_in = 16'h0;
   logic [3:0]          bank_select_reg_in = 4'h0;
   logic [11:0]         index_base_in = 12'h0;
   logic [7:0]          mem_rdata_in, acc_out, mem_wdata_out;
   logic [11:0]         mem_addr_out;
   logic                mem_rd_out, mem_wr_out, done_out;
   logic [1:0]          phase_out;
   aie_pkg::aie_flags_t flags_out;
   int                  error_cnt = 0, compares = 0, cycles = 0, m_acc = 0, mmem[4096];
   bit                  mc, mdc, mz, mov, mn;

   aie_execute dut (.clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
      .instr_in(instr_in), .bank_select_reg_in(bank_select_reg_in), .ext_set_en_in(ext_set_en_in),
      .index_base_in(index_base_in), .mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out),
      .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
      .acc_out(acc_out), .flags_out(flags_out), .phase_out(phase_out), .done_out(done_out));
   aie_data_mem mem (.clk_in(clk_in), .addr_in(mem_addr_out), .rd_in(mem_rd_out),
      .wr_in(mem_wr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      compares++;
      if (exp !== got) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("Counts: errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Issue one word, mirror it in the model, check at completion
   task automatic run(int op, logic [7:0] f, bit d, bit a, bit ext);
      logic [15:0] w;
      logic [11:0] adr;
      int          opd, cin, sum, res, n;
      bit          seen, file;
      seen = 0;
      n = 0;
      file = (op == 1 || op == 2);
      case (op)
         0: w = {aie_pkg::OPC_ADD_LIT, f};
         1: w = {aie_pkg::OPC_ADD_FILE, d, a, f};
         2: w = {aie_pkg::OPC_ADDC_FILE, d, a, f};
         3: w = {aie_pkg::OPC_AND_LIT, f};
         default: w = {8'hff, f};
      endcase
      bank_select_reg_in = 4'($urandom);
      ext_set_en_in = ext;
      instr_in = w;
      instr_valid_in = 1;
      if (a) adr = {bank_select_reg_in, f};
      else if (ext && f <= 8'h5f) adr = index_base_in + 12'(f);
      else adr = {(f < 8'h60) ? 4'h0 : 4'hf, f};
      opd = file ? mmem[adr] : int'(f);
      cin = (op == 2) ? int'(mc) : 0;
      sum = m_acc + opd + cin;
      res = (op == 3) ? (m_acc & int'(f)) : (sum & 255);
      if (op < 3) begin
         mdc = ((m_acc & 15) + (opd & 15) + cin) > 15;
         mc = sum > 255;
         mov = (((m_acc ^ opd) & 128) == 0) && (((m_acc ^ res) & 128) != 0);
      end
      if (op < 4) begin
         mn = res[7];
         mz = (res == 0);
         if (file && d) mmem[adr] = res;
         else m_acc = res;
      end
      for (int i = 0; i < 8; i++) begin
         @(negedge clk_in);
         if (phase_out != 2'd0) begin
            seen = 1;
            n++;
            chk("phase", 16'(n), phase_out);
            if (n == 1) chk("read strobe", 16'(file), mem_rd_out);
            instr_in = 16'($urandom);
            bank_select_reg_in = 4'($urandom);
            ext_set_en_in = 1'($urandom);
         end else if (seen) break;
      end
      chk("phases", 16'd3, 16'(n));
      chk("done", 16'(op < 4), done_out);
      chk("acc", 16'(m_acc), acc_out);
      chk("flags", {mn, mov, mz, mdc, mc}, flags_out);
      chk("write", 16'(file && d), mem_wr_out);
      if (file) chk("addr", adr, mem_addr_out);
      if (file && d) chk("wdata", 16'(res), mem_wdata_out);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 4096; i++) mmem[i] = (i * 37 + 11) & 255;
      void'($urandom(24));
      repeat (20) @(negedge clk_in);
      rst_in = 0;
      run(0, 8'h10, 0, 0, 0);
      run(0, 8'h15, 0, 0, 0);
      for (int i = 0; i < 400; i++) begin
         index_base_in = 12'($urandom);
         run($urandom_range(4, 0), ($urandom_range(3, 0) == 0) ? 8'h5f + 8'($urandom_range(1, 0)) : 8'($urandom),
             1'($urandom), 1'($urandom), 1'($urandom));
      end
      instr_valid_in = 0;
      repeat (6) @(negedge clk_in);
      chk("idle done", 16'h0, done_out);
      rst_in = 1;
      @(negedge clk_in);
      chk("reset acc", 16'h0, acc_out);
      chk("reset addr", 16'h0, mem_addr_out);
      chk("reset misc", 16'h0, {flags_out, phase_out, mem_rd_out, mem_wr_out, done_out});
      repeat (2) @(negedge clk_in);
      rst_in = 0;
      m_acc = 0;
      {mn, mov, mz, mdc, mc} = 5'h00;
      run(2, 8'h20, 1, 0, 0);
      run(1, 8'h20, 0, 1, 0);
      run(3, 8'h5f, 0, 0, 0);
      instr_valid_in = 0;
      repeat (2) @(negedge clk_in);
      wrap_up();
   end
endmodule // add_and_instruction_execute_bench
